// File: art_defs.vh
// Constants for the acquisition reference and pause trigger block
`ifndef ART_DEFS_VH
`define ART_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ART_OFF_CTRL 8'h00
`define ART_OFF_BUFSZ 8'h04
`define ART_OFF_PRE 8'h08
`define ART_OFF_SRC 8'h0c
`define ART_OFF_STATUS 8'h10
`define ART_OFF_COUNT 8'h14
`define ART_OFF_WPTR 8'h18
`define ART_OFF_TRIGPOS 8'h1c
`define ART_OFF_DATA 8'h20

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ART_CTRL_START 0
`define ART_CTRL_STOP 1
`define ART_CTRL_USE_START_TRIG 2
`define ART_CTRL_USE_REF 3
`define ART_CTRL_INT_CLK 4
`define ART_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// Source register fields
// ----------------------------------------
`define ART_SRC_REF_SEL_LO 0
`define ART_SRC_REF_SEL_HI 2
`define ART_SRC_REF_FALL 3
`define ART_SRC_PAUSE_SEL_LO 4
`define ART_SRC_PAUSE_SEL_HI 6
`define ART_SRC_PAUSE_LOW 7
`define ART_SRC_START_SEL_LO 8
`define ART_SRC_START_SEL_HI 10
`define ART_SRC_START_FALL 11
`define ART_SRC_PAUSE_EN 12
`define ART_SRC_REFOUT_INV 13
`define ART_SRC_REFOUT_SEL_LO 16
`define ART_SRC_REFOUT_SEL_HI 19
`define ART_SRC_RESET 32'h0000_0000

// ----------------------------------------
// Source selector codes
// ----------------------------------------
`define ART_SEL_TERM 3'h0
`define ART_SEL_INTERNAL 3'h1
`define ART_SEL_ANALOG 3'h2

// ----------------------------------------
// Sizes and widths
// ----------------------------------------
`define ART_AW 10
`define ART_DEPTH 1024
`define ART_NTERM 4
`define ART_TW 2
`define ART_CNT_W 11
`define ART_BUFSZ_RESET 11'h400
`define ART_PRE_RESET 11'h000

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define ART_RESP_OKAY 2'h0
`define ART_RESP_SLVERR 2'h2

// ----------------------------------------
// Acquisition states
// ----------------------------------------
`define ART_ST_IDLE 3'h0
`define ART_ST_WAIT_START 3'h1
`define ART_ST_PRE 3'h2
`define ART_ST_ARMED 3'h3
`define ART_ST_POST 3'h4
`define ART_ST_DONE 3'h5

`endif

// File: art_src_model.sv
// Behavioural sample clock and sample word source
`timescale 1ns/100ps
module art_src_model (
   input wire aclk,
   input wire run,
   input wire slow,
   output logic sample_tick,
   output logic [31:0] sample_data
);
   // ----
   // Tick pacing
   // ----
   logic [3:0] ph_q = 4'h0;
   initial sample_tick = 1'b0;
   initial sample_data = 32'h0;
   // Word changes every period so a stale capture never matches by chance
   always @(posedge aclk) begin
      ph_q <= (!run || ph_q == (slow ? 4'hf : 4'h7)) ? 4'h0 : ph_q + 4'h1;
      sample_tick <= run && ph_q < 4'h2;
      if (ph_q == 4'h0) sample_data <= sample_data * 32'h0001_0003 + 32'h1;
   end
endmodule

// File: art_trigger.v
// Reference and pause trigger control of a sampled acquisition with AXI4-Lite registers
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Reference acquisition needs finite buffer size and pretrigger count set before start.
// - Posttrigger count equals buffer size minus pretrigger count.
// - Every sample is stored (the code drops one taken with the accepted reference edge); reference detection arms after pretrigger samples are captured.
// - Reference conditions before pretrigger count is reached are ignored.
// - Full buffer without accepted trigger overwrites the oldest sample circularly.
// - After trigger, store posttrigger samples then stop with buffer complete.
// - Digital reference source: terminal or internal signal, rising or falling edge.
// - Analog reference stops on first configured edge of comparison event.
// - Reference trigger routable to any output terminal, active high by default.
// - Active pause level halts internal sample clock; inactive level resumes sampling.
// - Pause active level selectable high or low.
// - Digital pause: terminal or internal source with selected polarity.
// - Analog pause halts while comparison event low, runs while high, or inverted.
// - Pause responds to source level only, never to edges.
// - Acquisition begins on start trigger or software start; samples only afterwards.
// - Each sample clock pulse starts one sample reading every channel.
`include "art_defs.vh"

module art_trigger (
   input wire aclk,
   input wire aresetn,
   input wire [`ART_NTERM-1:0] term_in,
   input wire internal_trig,
   input wire analog_event,
   input wire sample_tick,
   input wire ext_sample_clk,
   input wire [31:0] sample_data,
   output reg [`ART_NTERM-1:0] term_out,
   output reg sample_strobe,
   output reg acq_done,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function pick;
      input [2:0] sel;
      input [`ART_NTERM-1:0] term;
      input intl;
      input ana;
      begin
         case (sel)
            `ART_SEL_TERM: pick = term[0];
            `ART_SEL_INTERNAL: pick = intl;
            `ART_SEL_ANALOG: pick = ana;
            default: pick = term[sel[`ART_TW-1:0]];
         endcase
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Pin inputs and the sample clock source come from outside the domain
   localparam NSYNC = `ART_NTERM + 4;
   wire [NSYNC-1:0] raw_in;
   reg [NSYNC-1:0] sync1_q;
   reg [NSYNC-1:0] sync2_q;
   assign raw_in = {ext_sample_clk, sample_tick, analog_event, internal_trig, term_in};

   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= {NSYNC{1'b0}};
         sync2_q <= {NSYNC{1'b0}};
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   wire [`ART_NTERM-1:0] term_s = sync2_q[`ART_NTERM-1:0];
   wire int_s = sync2_q[`ART_NTERM];
   wire ana_s = sync2_q[`ART_NTERM+1];
   wire tick_s = sync2_q[`ART_NTERM+2];
   wire extclk_s = sync2_q[`ART_NTERM+3];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [31:0] ctrl_q;
   reg [31:0] src_q;
   reg [`ART_CNT_W-1:0] bufsz_q;
   reg [`ART_CNT_W-1:0] pre_q;
   reg cfg_err_q;
   reg [2:0] state_q;
   reg [`ART_CNT_W-1:0] count_q;
   reg [`ART_CNT_W-1:0] post_q;
   reg [`ART_AW-1:0] wptr_q;
   reg [`ART_AW-1:0] trigpos_q;
   reg [`ART_AW-1:0] rdidx_q;
   reg [31:0] mem [0:`ART_DEPTH-1];
   reg ref_prev_q;
   reg start_prev_q;
   reg clk_prev_q;
   reg ref_hit_q;

   // ----------------------------------------
   // Trigger decode
   // ----------------------------------------
   wire ref_lvl = pick(src_q[`ART_SRC_REF_SEL_HI:`ART_SRC_REF_SEL_LO], term_s, int_s, ana_s);
   wire ref_raw = ref_lvl ^ src_q[`ART_SRC_REF_FALL];
   wire ref_edge = ref_raw & ~ref_prev_q;
   wire start_raw = pick(src_q[`ART_SRC_START_SEL_HI:`ART_SRC_START_SEL_LO], term_s, int_s, ana_s)
                    ^ src_q[`ART_SRC_START_FALL];
   wire start_edge = start_raw & ~start_prev_q;
   // Level only, no edge memory anywhere in this path
   wire pause_lvl = pick(src_q[`ART_SRC_PAUSE_SEL_HI:`ART_SRC_PAUSE_SEL_LO], term_s, int_s, ana_s);
   wire paused = src_q[`ART_SRC_PAUSE_EN] & (pause_lvl ^ src_q[`ART_SRC_PAUSE_LOW]);
   wire clk_src = ctrl_q[`ART_CTRL_INT_CLK] ? tick_s : extclk_s;
   wire clk_rise = clk_src & ~clk_prev_q;
   wire sample_go = clk_rise & ~paused;
   // Byte-merged size words, cut to the counter width
   wire [31:0] bufsz_wr = merge({21'h0, bufsz_q}, s_axi_wdata, s_axi_wstrb);
   wire [31:0] pre_wr = merge({21'h0, pre_q}, s_axi_wdata, s_axi_wstrb);
   wire [`ART_CNT_W-1:0] post_need = bufsz_q - pre_q;
   wire cfg_bad = (pre_q > bufsz_q) | (bufsz_q == {`ART_CNT_W{1'b0}}) | (bufsz_q > `ART_BUFSZ_RESET);
   wire acq_run = (state_q == `ART_ST_PRE) | (state_q == `ART_ST_ARMED) | (state_q == `ART_ST_POST);
   wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
   wire sw_start = wr_fire & (s_axi_awaddr == `ART_OFF_CTRL) & s_axi_wstrb[0] & s_axi_wdata[`ART_CTRL_START];
   wire sw_stop = wr_fire & (s_axi_awaddr == `ART_OFF_CTRL) & s_axi_wstrb[0] & s_axi_wdata[`ART_CTRL_STOP];

   // ----------------------------------------
   // Acquisition sequencer
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= `ART_ST_IDLE;
         count_q <= {`ART_CNT_W{1'b0}};
         post_q <= {`ART_CNT_W{1'b0}};
         wptr_q <= {`ART_AW{1'b0}};
         trigpos_q <= {`ART_AW{1'b0}};
         ref_prev_q <= 1'b0;
         start_prev_q <= 1'b0;
         clk_prev_q <= 1'b0;
         ref_hit_q <= 1'b0;
         sample_strobe <= 1'b0;
         acq_done <= 1'b0;
         cfg_err_q <= 1'b0;
      end else begin
         ref_prev_q <= ref_raw;
         start_prev_q <= start_raw;
         clk_prev_q <= clk_src;
         ref_hit_q <= 1'b0;
         sample_strobe <= 1'b0;
         if (sw_stop) begin
            state_q <= `ART_ST_IDLE;
         end else begin
            case (state_q)
               `ART_ST_IDLE, `ART_ST_DONE: begin
                  if (sw_start) begin
                     if (s_axi_wdata[`ART_CTRL_USE_REF] & cfg_bad) begin
                        cfg_err_q <= 1'b1;
                     end else begin
                        cfg_err_q <= 1'b0;
                        acq_done <= 1'b0;
                        count_q <= {`ART_CNT_W{1'b0}};
                        wptr_q <= {`ART_AW{1'b0}};
                        post_q <= post_need;
                        state_q <= s_axi_wdata[`ART_CTRL_USE_START_TRIG] ? `ART_ST_WAIT_START : `ART_ST_PRE;
                     end
                  end
               end
               `ART_ST_WAIT_START: begin
                  if (start_edge) begin
                     state_q <= `ART_ST_PRE;
                  end
               end
               `ART_ST_PRE, `ART_ST_ARMED: begin
                  if (state_q == `ART_ST_ARMED && ctrl_q[`ART_CTRL_USE_REF] && ref_edge) begin
                     ref_hit_q <= 1'b1;
                     trigpos_q <= wptr_q;
                     state_q <= (post_q == {`ART_CNT_W{1'b0}}) ? `ART_ST_DONE : `ART_ST_POST;
                     acq_done <= (post_q == {`ART_CNT_W{1'b0}});
                  end else if (sample_go) begin
                     sample_strobe <= 1'b1;
                     wptr_q <= (wptr_q + 1'b1 >= bufsz_q) ? {`ART_AW{1'b0}} : wptr_q + 1'b1;
                     if (count_q < bufsz_q) begin
                        count_q <= count_q + 1'b1;
                     end
                     if (!ctrl_q[`ART_CTRL_USE_REF] && count_q + 1'b1 >= bufsz_q) begin
                        state_q <= `ART_ST_DONE;
                        acq_done <= 1'b1;
                     end else if (count_q + 1'b1 >= pre_q) begin
                        state_q <= `ART_ST_ARMED;
                     end
                  end
               end
               `ART_ST_POST: begin
                  if (sample_go) begin
                     sample_strobe <= 1'b1;
                     wptr_q <= (wptr_q + 1'b1 >= bufsz_q) ? {`ART_AW{1'b0}} : wptr_q + 1'b1;
                     if (count_q < bufsz_q) begin
                        count_q <= count_q + 1'b1;
                     end
                     post_q <= post_q - 1'b1;
                     if (post_q == {{(`ART_CNT_W-1){1'b0}}, 1'b1}) begin
                        state_q <= `ART_ST_DONE;
                        acq_done <= 1'b1;
                     end
                  end
               end
               default: state_q <= `ART_ST_IDLE;
            endcase
         end
      end
   end

   // Sample store; no reset so it maps to block memory
   always @(posedge aclk) begin
      if (acq_run && sample_go) begin
         mem[wptr_q] <= sample_data;
      end
   end

   // ----------------------------------------
   // Reference trigger export
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `ART_NTERM; g = g + 1) begin : g_route
         always @(posedge aclk) begin
            if (!aresetn) begin
               term_out[g] <= 1'b0;
            end else begin
               term_out[g] <= (src_q[`ART_SRC_REFOUT_SEL_LO + g] & ref_hit_q) ^ src_q[`ART_SRC_REFOUT_INV];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // AXI4-Lite write
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `ART_CTRL_RESET;
         src_q <= `ART_SRC_RESET;
         bufsz_q <= `ART_BUFSZ_RESET;
         pre_q <= `ART_PRE_RESET;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ART_RESP_OKAY;
      end else begin
         s_axi_awready <= wr_fire;
         s_axi_wready <= wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `ART_RESP_OKAY;
            case (s_axi_awaddr)
               // Start and stop bits self-clear; they act as commands
               `ART_OFF_CTRL: ctrl_q <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb) & 32'hffff_fffc;
               `ART_OFF_SRC: src_q <= merge(src_q, s_axi_wdata, s_axi_wstrb);
               // Sizes are frozen in the pretrigger, armed and posttrigger states, but not while waiting for a start trigger
               `ART_OFF_BUFSZ: if (!acq_run) bufsz_q <= bufsz_wr[`ART_CNT_W-1:0];
               `ART_OFF_PRE: if (!acq_run) pre_q <= pre_wr[`ART_CNT_W-1:0];
               `ART_OFF_STATUS, `ART_OFF_COUNT, `ART_OFF_WPTR, `ART_OFF_TRIGPOS, `ART_OFF_DATA: ;
               default: s_axi_bresp <= `ART_RESP_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read
   // ----------------------------------------
   wire rd_fire = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ART_RESP_OKAY;
         rdidx_q <= {`ART_AW{1'b0}};
      end else begin
         s_axi_arready <= rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ART_RESP_OKAY;
            case (s_axi_araddr)
               `ART_OFF_CTRL: s_axi_rdata <= ctrl_q;
               `ART_OFF_SRC: s_axi_rdata <= src_q;
               `ART_OFF_BUFSZ: s_axi_rdata <= {21'h0, bufsz_q};
               `ART_OFF_PRE: s_axi_rdata <= {21'h0, pre_q};
               `ART_OFF_STATUS: s_axi_rdata <= {27'h0, cfg_err_q, acq_run, state_q};
               `ART_OFF_COUNT: s_axi_rdata <= {21'h0, count_q};
               `ART_OFF_WPTR: s_axi_rdata <= {22'h0, wptr_q};
               `ART_OFF_TRIGPOS: s_axi_rdata <= {22'h0, trigpos_q};
               `ART_OFF_DATA: begin
                  // Reads walk the buffer in storage order
                  s_axi_rdata <= mem[rdidx_q];
                  rdidx_q <= (rdidx_q + 1'b1 >= bufsz_q) ? {`ART_AW{1'b0}} : rdidx_q + 1'b1;
               end
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `ART_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// File: art_trigger_assertions.sv
// Port-level concurrent checks for the acquisition trigger block
`timescale 1ns/100ps
`include "art_defs.vh"
module art_trigger_chk (
   input wire aclk,
   input wire aresetn,
   input wire [`ART_NTERM-1:0] term_out,
   input wire sample_strobe,
   input wire acq_done,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   // ----
   // Bus and acquisition properties
   // ----
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
   endproperty
   a_wr_take: assert property (p_wr_take) else $error("write not answered after one cycle");
   property p_rd_take; s_axi_arvalid && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid; endproperty
   a_rd_take: assert property (p_rd_take) else $error("read not answered after one cycle");
   property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && !s_axi_awready; endproperty
   a_b_once: assert property (p_b_once) else $error("write response repeated");
   property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !s_axi_arready; endproperty
   a_r_once: assert property (p_r_once) else $error("read response repeated");
   property p_reset_out; $rose(aresetn) |-> term_out == 0 && !acq_done && !sample_strobe && !s_axi_rvalid; endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
   // Only a register write may end the done state, so any write masks the check
   property p_done_hold; acq_done && !s_axi_awvalid |=> acq_done; endproperty
   a_done_hold: assert property (p_done_hold) else $error("done dropped without a write");
   property p_done_quiet; acq_done ##1 acq_done |-> !sample_strobe; endproperty
   a_done_quiet: assert property (p_done_quiet) else $error("sample stored after completion");
   property p_unmapped; s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 8'h23 |=>
      s_axi_rresp == `ART_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule
bind art_trigger art_trigger_chk art_trigger_chk_i (.*);

// File: art_trigger_bench.sv
// Self-checking bench for the acquisition trigger block
`timescale 1ns/100ps
`include "art_defs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module art_trigger_bench;
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, slow = 1'b0;
   logic [`ART_NTERM-1:0] term_in = 4'h0;
   logic internal_trig = 1'b0, analog_event = 1'b0, ext_sample_clk = 1'b0;
   wire sample_tick, sample_strobe, acq_done;
   wire [31:0] sample_data, s_axi_rdata;
   wire [`ART_NTERM-1:0] term_out;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   int errors = 0, num_checks = 0, strobes = 0, refs = 0, seed = 83;
   logic [3:0] last_ref = 4'h0;
   logic [31:0] hist[4];
   int pw[3] = '{3, 1, 2};
   logic pact[3] = '{1'b1, 1'b0, 1'b0};
   logic [31:0] psrc[3] = '{32'h1060, 32'h1090, 32'h10a0};
   art_trigger art_trigger_i (.*);
   art_src_model art_src_model_i (.aclk(aclk), .run(run), .slow(slow), .sample_tick(sample_tick),
      .sample_data(sample_data));
   initial begin
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (sample_strobe === 1'b1) strobes <= strobes + 1;
      if (term_out !== 4'h0) refs <= refs + 1;
      if (term_out !== 4'h0) last_ref <= term_out;
      // External clock lags the internal tick by one cycle
      ext_sample_clk <= sample_tick;
      if (sample_strobe === 1'b1) hist <= '{sample_data, hist[0], hist[1], hist[2]};
   end
   // ----
   // Shared tasks
   // ----
   function automatic int post_cnt(input int bsz, input int pre);
      return bsz - pre;
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic hang();
      errors++;
      $display("timeout at %0t", $time);
      stop_test();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) hang();
      `CHK(s_axi_bresp, `ART_RESP_OKAY)
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      if (n == 50) hang();
      `CHK(s_axi_rresp, er)
   endtask
   task automatic wait_strobes(input int k);
      int n;
      int t;
      t = strobes + k;
      for (n = 0; n < 600 && strobes < t; n++) @(posedge aclk);
      if (n == 600) hang();
   endtask
   task automatic wait_done();
      int n;
      for (n = 0; n < 600 && acq_done !== 1'b1; n++) @(posedge aclk);
      if (n == 600) hang();
   endtask
   // Line index: 0 terminal 0, 1 internal, 2 analog, 3 and 4 terminals 2 and 3
   task automatic set_line(input int w, input logic v);
      @(posedge aclk);
      case (w)
         0: term_in[0] <= v;
         1: internal_trig <= v;
         2: analog_event <= v;
         default: term_in[w - 1] <= v;
      endcase
   endtask
   task automatic pulse(input int w, input logic idle);
      set_line(w, !idle);
      @(posedge aclk);
      set_line(w, idle);
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      logic [31:0] d;
      logic fall;
      int i, w, s0, s1, r0, pre;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      run <= 1'b1;
      rd(`ART_OFF_BUFSZ, `ART_RESP_OKAY, d);
      `CHK(d[10:0], `ART_BUFSZ_RESET)
      rd(`ART_OFF_PRE, `ART_RESP_OKAY, d);
      `CHK(d[10:0], `ART_PRE_RESET)
      rd(`ART_OFF_SRC, `ART_RESP_OKAY, d);
      `CHK(d, `ART_SRC_RESET)
      rd(8'h40, `ART_RESP_SLVERR, d);
      `CHK(d, 32'h0)
      $display("test registers done");
      for (i = 0; i < 2; i++) begin
         wr(`ART_OFF_BUFSZ, i ? 32'h0 : 32'h8);
         wr(`ART_OFF_PRE, i ? 32'h0 : 32'h9);
         wr(`ART_OFF_CTRL, 32'h19);
         rd(`ART_OFF_STATUS, `ART_RESP_OKAY, d);
         `CHK(d[4:0], {2'h2, `ART_ST_IDLE})
      end
      $display("test config refusal done");
      // Early edge lands before the pretrigger count, later one after a wrap
      for (i = 0; i < 4; i++) begin
         fall = (i == 1) || (i == 3);
         w = (i < 2) ? i : 2;
         set_line(w, fall);
         pre = 3 + {$random(seed)} % 4;
         wr(`ART_OFF_SRC, {28'h0002000, fall, 3'(w)});
         wr(`ART_OFF_BUFSZ, 32'h8);
         wr(`ART_OFF_PRE, 32'(pre));
         r0 = refs;
         s0 = strobes;
         wr(`ART_OFF_CTRL, 32'h19);
         pulse(w, fall);
         wait_strobes(pre + 6 + {$random(seed)} % 3);
         `CHK(refs, r0)
         rd(`ART_OFF_WPTR, `ART_RESP_OKAY, d);
         `CHK(d[9:0], 10'((strobes - s0) % 8))
         rd(`ART_OFF_STATUS, `ART_RESP_OKAY, d);
         `CHK(d[2:0], `ART_ST_ARMED)
         wait_strobes(1);
         s1 = strobes;
         pulse(w, fall);
         wait_done();
         repeat (20) @(posedge aclk);
         `CHK(strobes - s1, post_cnt(8, pre))
         `CHK(refs, r0 + 1)
         `CHK(last_ref, 4'h2)
         rd(`ART_OFF_STATUS, `ART_RESP_OKAY, d);
         `CHK(d[2:0], `ART_ST_DONE)
         $display("test reference %0d done", i);
      end
      slow <= 1'b1;
      for (i = 0; i < 3; i++) begin
         set_line(pw[i], pact[i]);
         wr(`ART_OFF_SRC, psrc[i]);
         wr(`ART_OFF_BUFSZ, 32'h400);
         wr(`ART_OFF_CTRL, 32'h11);
         repeat (20) @(posedge aclk);
         s0 = strobes;
         repeat (80) @(posedge aclk);
         `CHK(strobes, s0)
         set_line(pw[i], !pact[i]);
         repeat (80) @(posedge aclk);
         `CHK(strobes > s0, 1'b1)
         wr(`ART_OFF_CTRL, 32'h2);
         $display("test pause %0d done", i);
      end
      wr(`ART_OFF_SRC, 32'h0000_0700);
      wr(`ART_OFF_BUFSZ, 32'h4);
      s0 = strobes;
      wr(`ART_OFF_CTRL, 32'h05);
      repeat (60) @(posedge aclk);
      `CHK(strobes, s0)
      set_line(4, 1'b1);
      wait_done();
      repeat (40) @(posedge aclk);
      `CHK(strobes - s0, 4)
      for (i = 0; i < 4; i++) begin
         rd(`ART_OFF_DATA, `ART_RESP_OKAY, d);
         `CHK(d, hist[3 - i])
      end
      $display("test start trigger done");
      stop_test();
   end
endmodule
